// ===== hdl/isf_pkg.sv
package isf_pkg;
    localparam int unsigned FES_SPEED_OBS_BIT  = 0;
    localparam int unsigned FES_DIST_OBS_BIT   = 1;
    localparam int unsigned FES_INERTIA_SW_BIT = 3;
    localparam int unsigned FES_ANALOG_TFF_BIT = 5;
    localparam logic [15:0] ANALOG_GAIN_MIN    = 16'h000a;
    localparam int          FF_AMOUNT_DEN      = 1000;
    localparam int          INERTIA_DEN        = 100;
    localparam int          ANALOG_GAIN_DEN    = 100;
    localparam int          CORE_CLK_NS        = 20;
    localparam int          CTRL_CYCLE_NS      = 50000;
    localparam int          FILT_UNIT_NS       = 10000;
    localparam int          CYC_PER_TICK       = CTRL_CYCLE_NS / CORE_CLK_NS;
    localparam int          FILT_CYC_UNITS     = CTRL_CYCLE_NS / FILT_UNIT_NS;
    localparam logic [15:0] RST_RATIO          = 16'h0000;
    localparam logic [15:0] RST_CMD            = 16'h0000;

    typedef enum logic [1:0] {
        ISF_MODE_POSITION,
        ISF_MODE_SPEED,
        ISF_MODE_TORQUE,
        ISF_MODE_FULL_CLOSED
    } isf_mode_t;

    typedef struct packed {
        logic servo_on;
        logic motor_fault;
        logic autotune_en;
        logic adaptive_filter_en;
    } isf_state_t;

    typedef struct packed {
        logic signed [15:0] pos_cmd_delta;
        logic signed [15:0] pos_loop_speed_cmd;
        logic signed [15:0] speed_cmd;
        logic signed [15:0] speed_loop_torque_cmd;
        logic signed [15:0] analog_in3;
    } isf_loop_in_t;

    typedef struct packed {
        logic signed [15:0] speed_cmd;
        logic signed [15:0] torque_cmd;
    } isf_loop_out_t;

    function automatic logic signed [15:0] isf_sat16(input logic signed [47:0] v);
        if (v > 48'sd32767) begin
            return 16'sh7fff;
        end else if (v < -48'sd32768) begin
            return 16'sh8000;
        end
        return v[15:0];
    endfunction : isf_sat16

    function automatic logic signed [15:0] isf_scale(input logic signed [31:0] val,
                                                      input logic [15:0]        amt,
                                                      input int                 den);
        logic signed [47:0] prod;
        prod = 48'(val) * $signed({32'h0, amt});
        return isf_sat16(prod / 48'(den));
    endfunction : isf_scale
endpackage : isf_pkg

// ===== hdl/isf_lag_filter.sv
`timescale 1ns/1ns
`default_nettype none
module isf_lag_filter (
    input  wire logic               core_clk,
    input  wire logic               rst_sync_b,
    input  wire logic               tick,
    input  wire logic        [15:0] time_const,
    input  wire logic signed [15:0] x,
    output logic signed      [15:0] y
);
    logic signed [15:0] y_ff;
    logic signed [15:0] nxt_y;
    logic signed [31:0] diff;
    logic signed [31:0] step;

    always_comb begin
        diff  = 32'(x) - 32'(y_ff);
        step  = (diff * 32'(isf_pkg::FILT_CYC_UNITS))
                / (32'(isf_pkg::FILT_CYC_UNITS) + $signed({16'h0, time_const}));
        nxt_y = y_ff;
        if (tick) begin
            // first-order lag; a zero constant passes the input straight through
            nxt_y = isf_pkg::isf_sat16(48'(y_ff) + 48'(step)); // RL11 RL13
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            y_ff <= isf_pkg::RST_CMD;
        end else begin
            y_ff <= nxt_y;
        end
    end

    assign y = y_ff;

    a_lag_passthru: assert property (@(posedge core_clk) disable iff (!rst_sync_b) // RL11
        tick && time_const == 16'h0000 |=> y == $past(x))
        else $error("lag filter with zero constant did not pass input");
    a_lag_hold_idle: assert property (@(posedge core_clk) disable iff (!rst_sync_b) // RL13
        !tick |=> $stable(y))
        else $error("lag filter output moved without a tick");
endmodule : isf_lag_filter
`default_nettype wire

// ===== hdl/isf_top.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// RL1: pick stored inertia ratio one or two
// RL2: function expansion bit 3 enables selection
// RL3: selection disabled gives ratio one at each tick inside the RL6 window
// RL4: enabled and input asserted gives ratio two
// RL5: enabled and input deasserted gives ratio one
// RL6: selection acts only servo on, healthy, aids off
// RL7: host changes select input only at standstill
// RL8: hybrid suppression only fully-closed, servo on, healthy
// RL9: software sets hybrid gain near position gain
// RL10: scaled position command speed added to speed
// RL11: speed feed-forward term passes first-order lag
// RL12: scaled speed command torque added to torque
// RL13: torque feed-forward term passes first-order lag
// RL14: analog gain zero to nine disables path
// RL15: analog path needs bit 5, input unclaimed
// RL16: settings applied once per control cycle
module isf_top (
    input  wire logic                   core_clk,
    input  wire logic                   rst_b,
    input  wire logic                   ctrl_tick,
    input  wire isf_pkg::isf_mode_t     control_mode,
    input  wire isf_pkg::isf_state_t    drive_state,
    input  wire logic            [15:0] function_expansion_setting,
    input  wire logic            [15:0] inertia_ratio_one,
    input  wire logic            [15:0] inertia_ratio_two,
    input  wire logic                   inertia_select_input,
    input  wire logic            [15:0] hybrid_suppress_gain,
    input  wire logic            [15:0] hybrid_suppress_filter,
    input  wire logic            [15:0] speed_ff_amount,
    input  wire logic            [15:0] speed_ff_filter,
    input  wire logic            [15:0] torque_ff_amount,
    input  wire logic            [15:0] torque_ff_filter,
    input  wire logic            [15:0] analog_torque_ff_gain,
    input  wire logic                   analog_in3_claimed,
    input  wire isf_pkg::isf_loop_in_t  loop_in,
    output logic                 [15:0] inertia_ratio_active,
    output logic                        inertia_second_sel,
    output logic                        hybrid_active,
    output logic                 [15:0] hybrid_gain_active,
    output logic                 [15:0] hybrid_filter_active,
    output logic                        analog_tff_active,
    output isf_pkg::isf_loop_out_t      loop_out
);
    logic                  rst_meta_ff;
    logic                  rst_sync_ff;
    logic                  sel_second_ff,   nxt_sel_second;
    logic [15:0]           ratio_ff,        nxt_ratio;
    logic                  hybrid_ff,       nxt_hybrid;
    logic [15:0]           hgain_ff,        nxt_hgain;
    logic [15:0]           hfilt_ff,        nxt_hfilt;
    logic                  atff_ff,         nxt_atff;
    logic [15:0]           sff_amt_ff,      nxt_sff_amt;
    logic [15:0]           sff_tc_ff,       nxt_sff_tc;
    logic [15:0]           tff_amt_ff,      nxt_tff_amt;
    logic [15:0]           tff_tc_ff,       nxt_tff_tc;
    logic signed [15:0]    prev_spd_ff,     nxt_prev_spd;
    isf_pkg::isf_loop_out_t out_ff,         nxt_out;
    logic                  sel_allowed;
    logic                  pos_modes;
    logic signed [15:0]    sff_raw;
    logic signed [15:0]    tff_raw;
    logic signed [15:0]    sff_filt;
    logic signed [15:0]    tff_filt;
    logic signed [15:0]    analog_term;
    logic signed [15:0]    accel;

    // two-stage release; the first flop feeds only the second
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // observer enables live in the expansion word itself
    assign sel_allowed = drive_state.servo_on && !drive_state.motor_fault
                         && !drive_state.autotune_en && !drive_state.adaptive_filter_en
                         && !function_expansion_setting[isf_pkg::FES_SPEED_OBS_BIT]
                         && !function_expansion_setting[isf_pkg::FES_DIST_OBS_BIT]; // RL6
    assign pos_modes   = control_mode == isf_pkg::ISF_MODE_POSITION
                         || control_mode == isf_pkg::ISF_MODE_FULL_CLOSED;

    // inertia selection: outside the allowed window the last choice is kept so a
    // fault or servo-off does not jolt the loop with a new ratio
    always_comb begin
        nxt_sel_second = sel_second_ff;
        if (ctrl_tick && sel_allowed) begin // RL16
            if (!function_expansion_setting[isf_pkg::FES_INERTIA_SW_BIT]) begin // RL2
                nxt_sel_second = 1'b0; // RL3
            end else begin
                nxt_sel_second = inertia_select_input; // RL4 RL5
            end
        end
        nxt_ratio = ratio_ff;
        if (ctrl_tick) begin
            nxt_ratio = nxt_sel_second ? inertia_ratio_two : inertia_ratio_one; // RL1
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            sel_second_ff <= 1'b0;
            ratio_ff      <= isf_pkg::RST_RATIO;
        end else begin
            sel_second_ff <= nxt_sel_second;
            ratio_ff      <= nxt_ratio;
        end
    end

    // hybrid suppression gate and parameter capture
    always_comb begin
        nxt_hybrid  = hybrid_ff;
        nxt_hgain   = hgain_ff;
        nxt_hfilt   = hfilt_ff;
        nxt_atff    = atff_ff;
        nxt_sff_amt = sff_amt_ff;
        nxt_sff_tc  = sff_tc_ff;
        nxt_tff_amt = tff_amt_ff;
        nxt_tff_tc  = tff_tc_ff;
        if (ctrl_tick) begin // RL16
            nxt_hybrid  = control_mode == isf_pkg::ISF_MODE_FULL_CLOSED
                          && drive_state.servo_on && !drive_state.motor_fault; // RL8
            nxt_hgain   = hybrid_suppress_gain;
            nxt_hfilt   = hybrid_suppress_filter;
            nxt_atff    = function_expansion_setting[isf_pkg::FES_ANALOG_TFF_BIT]
                          && !analog_in3_claimed
                          && analog_torque_ff_gain >= isf_pkg::ANALOG_GAIN_MIN; // RL14 RL15
            nxt_sff_amt = speed_ff_amount;
            nxt_sff_tc  = speed_ff_filter;
            nxt_tff_amt = torque_ff_amount;
            nxt_tff_tc  = torque_ff_filter;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            hybrid_ff  <= 1'b0;
            hgain_ff   <= isf_pkg::RST_RATIO;
            hfilt_ff   <= isf_pkg::RST_RATIO;
            atff_ff    <= 1'b0;
            sff_amt_ff <= isf_pkg::RST_RATIO;
            sff_tc_ff  <= isf_pkg::RST_RATIO;
            tff_amt_ff <= isf_pkg::RST_RATIO;
            tff_tc_ff  <= isf_pkg::RST_RATIO;
        end else begin
            hybrid_ff  <= nxt_hybrid;
            hgain_ff   <= nxt_hgain;
            hfilt_ff   <= nxt_hfilt;
            atff_ff    <= nxt_atff;
            sff_amt_ff <= nxt_sff_amt;
            sff_tc_ff  <= nxt_sff_tc;
            tff_amt_ff <= nxt_tff_amt;
            tff_tc_ff  <= nxt_tff_tc;
        end
    end

    // feed-forward terms; torque uses the inertia ratio in force
    assign accel       = isf_pkg::isf_sat16(48'(loop_in.speed_cmd) - 48'(prev_spd_ff));
    assign sff_raw     = pos_modes ? isf_pkg::isf_scale(32'(loop_in.pos_cmd_delta), sff_amt_ff,
                                                        isf_pkg::FF_AMOUNT_DEN)
                                   : 16'sh0000; // RL10
    assign tff_raw     = isf_pkg::isf_scale(
                             32'(isf_pkg::isf_scale(32'(accel), ratio_ff + 16'h0064,
                                                    isf_pkg::INERTIA_DEN)),
                             tff_amt_ff, isf_pkg::FF_AMOUNT_DEN); // RL12
    assign analog_term = atff_ff ? isf_pkg::isf_scale(32'(loop_in.analog_in3),
                                                      analog_torque_ff_gain,
                                                      isf_pkg::ANALOG_GAIN_DEN)
                                 : 16'sh0000; // RL14

    isf_lag_filter u_speed_lag (
        .core_clk   (core_clk),
        .rst_sync_b (rst_sync_ff),
        .tick       (ctrl_tick),
        .time_const (sff_tc_ff),
        .x          (sff_raw),
        .y          (sff_filt)
    ); // RL11

    isf_lag_filter u_torque_lag (
        .core_clk   (core_clk),
        .rst_sync_b (rst_sync_ff),
        .tick       (ctrl_tick),
        .time_const (tff_tc_ff),
        .x          (tff_raw),
        .y          (tff_filt)
    ); // RL13

    // outputs saturate rather than wrap so an overdriven term cannot flip sign
    always_comb begin
        nxt_out      = out_ff;
        nxt_prev_spd = prev_spd_ff;
        if (ctrl_tick) begin // RL16
            nxt_out.speed_cmd  = isf_pkg::isf_sat16(48'(loop_in.pos_loop_speed_cmd)
                                                    + 48'(sff_filt)); // RL10
            nxt_out.torque_cmd = isf_pkg::isf_sat16(48'(loop_in.speed_loop_torque_cmd)
                                                    + 48'(tff_filt) + 48'(analog_term)); // RL12
            nxt_prev_spd       = loop_in.speed_cmd;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            out_ff      <= '0;
            prev_spd_ff <= isf_pkg::RST_CMD;
        end else begin
            out_ff      <= nxt_out;
            prev_spd_ff <= nxt_prev_spd;
        end
    end

    assign inertia_ratio_active = ratio_ff;
    assign inertia_second_sel   = sel_second_ff;
    assign hybrid_active        = hybrid_ff;
    assign hybrid_gain_active   = hybrid_ff ? hgain_ff : 16'h0000;
    assign hybrid_filter_active = hfilt_ff;
    assign analog_tff_active    = atff_ff;
    assign loop_out             = out_ff;

    sequence s_sel_tick;
        ctrl_tick && sel_allowed;
    endsequence

    a_sel_off_first: assert property (@(posedge core_clk) disable iff (!rst_sync_ff) // RL3
        (s_sel_tick and !function_expansion_setting[isf_pkg::FES_INERTIA_SW_BIT])
            |=> !inertia_second_sel
            && inertia_ratio_active == $past(inertia_ratio_one))
        else $error("disabled selection did not give ratio one");
    a_sel_on_second: assert property (@(posedge core_clk) disable iff (!rst_sync_ff) // RL4
        (s_sel_tick and (function_expansion_setting[isf_pkg::FES_INERTIA_SW_BIT]
            && inertia_select_input))
            |=> inertia_ratio_active == $past(inertia_ratio_two))
        else $error("asserted select did not give ratio two");
    a_sel_on_first: assert property (@(posedge core_clk) disable iff (!rst_sync_ff) // RL5
        (s_sel_tick and (function_expansion_setting[isf_pkg::FES_INERTIA_SW_BIT]
            && !inertia_select_input))
            |=> !inertia_second_sel)
        else $error("deasserted select did not give ratio one");
    a_sel_gate_hold: assert property (@(posedge core_clk) disable iff (!rst_sync_ff) // RL6
        ctrl_tick && !sel_allowed |=> $stable(inertia_second_sel))
        else $error("selection changed while not allowed");
    a_hybrid_gate: assert property (@(posedge core_clk) disable iff (!rst_sync_ff) // RL8
        ctrl_tick |=> hybrid_active == ($past(control_mode) == isf_pkg::ISF_MODE_FULL_CLOSED
            && $past(drive_state.servo_on) && !$past(drive_state.motor_fault)))
        else $error("hybrid gate wrong");
    a_analog_low_gain: assert property (@(posedge core_clk) disable iff (!rst_sync_ff) // RL14
        ctrl_tick && analog_torque_ff_gain < 16'h000a |=> !analog_tff_active)
        else $error("analog path on with gain below ten");
    a_analog_claim: assert property (@(posedge core_clk) disable iff (!rst_sync_ff) // RL15
        ctrl_tick && (analog_in3_claimed || !function_expansion_setting[5])
            |=> !analog_tff_active)
        else $error("analog path on while claimed or disabled");
    a_speed_no_ff: assert property (@(posedge core_clk) disable iff (!rst_sync_ff) // RL10
        ctrl_tick && sff_filt == 16'sh0000 |=> loop_out.speed_cmd
            == $past(loop_in.pos_loop_speed_cmd))
        else $error("speed output not loop command plus term");
    a_out_per_tick: assert property (@(posedge core_clk) disable iff (!rst_sync_ff) // RL16
        !ctrl_tick [*2] |-> $stable(loop_out))
        else $error("outputs moved outside a control tick");
endmodule : isf_top
`default_nettype wire

// ===== test/isf_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module isf_host_model #(
    parameter int TICK_GAP = 8
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        sel_req,
    input  wire logic        moving,
    input  wire logic [15:0] pos_gain,
    output logic             ctrl_tick,
    output logic             inertia_select_input,
    output logic      [15:0] hybrid_suppress_gain
);
    int cnt;
    assign hybrid_suppress_gain = pos_gain;
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            ctrl_tick <= 1'b0;
            inertia_select_input <= 1'b0;
        end else begin
            cnt <= (cnt == TICK_GAP - 1) ? 0 : cnt + 1;
            ctrl_tick <= (cnt == TICK_GAP - 1);
            // a request made while moving waits for standstill
            if (!moving) begin
                inertia_select_input <= sel_req;
            end
        end
    end
endmodule : isf_host_model
`default_nettype wire

// ===== test/inertia_select_feedforward_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module inertia_select_feedforward_tb_top;
    logic                   core_clk, rst_b, ctrl_tick, sel_in, sel_req, claimed;
    logic                   sel2, hyb_act, an_act;
    isf_pkg::isf_mode_t     mode;
    isf_pkg::isf_state_t    ds;
    isf_pkg::isf_loop_in_t  li;
    isf_pkg::isf_loop_out_t lo;
    logic            [15:0] fes, r1, r2, hgain, hfilt, samt, sfilt, tamt, tfilt, again, pgain;
    logic            [15:0] ratio_act, hgain_act, hfilt_act;
    int                     error_cnt, check_count, cyc, m_sel, m_ratio, m_prev, m_acc, mx;

    isf_host_model isf_host_model_inst (
        .core_clk(core_clk), .rst_b(rst_b), .sel_req(sel_req),
        .moving(li.pos_cmd_delta != 16'h0000), .pos_gain(pgain), .ctrl_tick(ctrl_tick),
        .inertia_select_input(sel_in), .hybrid_suppress_gain(hgain));

    isf_top isf_top_inst (
        .core_clk(core_clk), .rst_b(rst_b), .ctrl_tick(ctrl_tick), .control_mode(mode),
        .drive_state(ds), .function_expansion_setting(fes), .inertia_ratio_one(r1),
        .inertia_ratio_two(r2), .inertia_select_input(sel_in), .hybrid_suppress_gain(hgain),
        .hybrid_suppress_filter(hfilt), .speed_ff_amount(samt), .speed_ff_filter(sfilt),
        .torque_ff_amount(tamt), .torque_ff_filter(tfilt), .analog_torque_ff_gain(again),
        .analog_in3_claimed(claimed), .loop_in(li), .inertia_ratio_active(ratio_act),
        .inertia_second_sel(sel2), .hybrid_active(hyb_act), .hybrid_gain_active(hgain_act),
        .hybrid_filter_active(hfilt_act), .analog_tff_active(an_act), .loop_out(lo));

    always #10 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            $display("[FAIL] %0t run timed out", $time);
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : cmp_bit

    function automatic int clamp(input int v);
        return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
    endfunction : clamp

    // model state follows the inputs the design sampled at each tick edge
    task automatic tick_wait(input int n);
        int guard;
        repeat (n) begin
            guard = 0;
            do begin
                @(posedge core_clk);
                guard++;
            end while (ctrl_tick !== 1'b1 && guard < 100);
            if (ds.servo_on && !ds.motor_fault && !ds.autotune_en && !ds.adaptive_filter_en
                    && fes[1:0] == 2'h0) begin
                m_sel = fes[isf_pkg::FES_INERTIA_SW_BIT] & sel_in;
                m_ratio = m_sel ? r2 : r1;
            end
            m_acc = li.speed_cmd - m_prev;
            m_prev = li.speed_cmd;
        end
    endtask : tick_wait

    // steady-state expectations: inputs must have been constant for a few ticks
    task automatic check_all();
        logic h, a;
        int   sp, tq, an;
        @(posedge core_clk);
        h = mode == isf_pkg::ISF_MODE_FULL_CLOSED && ds.servo_on && !ds.motor_fault;
        a = fes[isf_pkg::FES_ANALOG_TFF_BIT] && !claimed && again >= isf_pkg::ANALOG_GAIN_MIN;
        an = a ? li.analog_in3 * int'(again) / 100 : 0;
        sp = li.pos_loop_speed_cmd;
        if (mode inside {isf_pkg::ISF_MODE_POSITION, isf_pkg::ISF_MODE_FULL_CLOSED}) begin
            sp += li.pos_cmd_delta * int'(samt) / 1000;
        end
        tq = li.speed_loop_torque_cmd + clamp(m_acc * (m_ratio + 100) / 100 * int'(tamt) / 1000);
        tq += an;
        cmp_bit(sel2, m_sel[0], "second ratio flag");
        cmp_word(ratio_act, 16'(m_ratio), "active ratio");
        cmp_bit(hyb_act, h, "hybrid active");
        cmp_word(hgain_act, h ? hgain : 16'h0000, "hybrid gain");
        cmp_word(hfilt_act, hfilt, "hybrid filter");
        cmp_bit(an_act, a, "analog ff active");
        cmp_word(lo.speed_cmd, 16'(clamp(sp)), "speed out");
        cmp_word(lo.torque_cmd, 16'(clamp(tq)), "torque out");
    endtask : check_all

    task automatic set_block(input int b, input logic on);
        case (b)
            0: ds.servo_on <= !on;
            1: ds.motor_fault <= on;
            2: ds.autotune_en <= on;
            3: ds.adaptive_filter_en <= on;
            default: fes[b - 4] <= on;
        endcase
    endtask : set_block

    task automatic rand_loop();
        li.pos_cmd_delta <= 16'(int'($urandom_range(2000)) - 1000);
        li.pos_loop_speed_cmd <= 16'(int'($urandom_range(20000)) - 10000);
        li.speed_cmd <= 16'(int'($urandom_range(20000)) - 10000);
        li.speed_loop_torque_cmd <= 16'(int'($urandom_range(20000)) - 10000);
        li.analog_in3 <= 16'(100 * (int'($urandom_range(10)) - 5));
        samt <= 16'($urandom_range(2000));
        again <= 16'($urandom_range(99));
        pgain <= 16'($urandom);
        hfilt <= 16'($urandom);
    endtask : rand_loop

    initial begin
        void'($urandom(70050));
        core_clk = 1'b0;
        rst_b = 1'b0;
        {sel_req, claimed, fes, hfilt, samt, sfilt, tamt, tfilt, again, pgain} = '0;
        {error_cnt, check_count, cyc, m_sel, m_ratio, m_prev, m_acc, mx} = '0;
        li = '0;
        ds = '0;
        ds.servo_on = 1'b1;
        mode = isf_pkg::ISF_MODE_POSITION;
        r1 = 16'($urandom_range(500));
        r2 = 16'($urandom_range(1000, 501));
        repeat (6) @(posedge core_clk);
        cmp_word(ratio_act, 16'h0000, "ratio in reset");
        cmp_word(lo.torque_cmd, 16'h0000, "torque in reset");
        rst_b <= 1'b1;
        tick_wait(3);
        for (int i = 0; i < 4; i++) begin
            fes[isf_pkg::FES_INERTIA_SW_BIT] <= i[1];
            sel_req <= i[0];
            tick_wait(4);
            check_all();
        end
        for (int b = 0; b < 6; b++) begin
            set_block(b, 1'b1);
            sel_req <= !sel_req;
            tick_wait(4);
            check_all();
            set_block(b, 1'b0);
            tick_wait(4);
            check_all();
        end
        for (int i = 0; i < 12; i++) begin
            mode <= isf_pkg::isf_mode_t'(i % 4);
            ds.servo_on <= i / 4 != 1;
            ds.motor_fault <= i / 4 == 2;
            rand_loop();
            tick_wait(4);
            check_all();
        end
        mode <= isf_pkg::ISF_MODE_POSITION;
        ds.servo_on <= 1'b1;
        ds.motor_fault <= 1'b0;
        samt <= 16'h03e8;
        for (int s = 0; s < 2; s++) begin
            li.pos_loop_speed_cmd <= s ? 16'sh8300 : 16'sh7d00;
            li.pos_cmd_delta <= s ? 16'shf830 : 16'sh07d0;
            tick_wait(4);
            check_all();
        end
        for (int i = 0; i < 4; i++) begin
            fes[isf_pkg::FES_ANALOG_TFF_BIT] <= i != 2;
            claimed <= i == 3;
            again <= i == 0 ? 16'h0009 : 16'h000a;
            li.analog_in3 <= 16'sh01f4;
            tick_wait(4);
            check_all();
        end
        tamt <= 16'h03e8;
        for (int j = 0; j < 6; j++) begin
            li.speed_cmd <= li.speed_cmd + 16'sh0064;
            tick_wait(1);
        end
        check_all();
        {li.pos_cmd_delta, li.pos_loop_speed_cmd, li.speed_loop_torque_cmd} <= '0;
        fes[isf_pkg::FES_ANALOG_TFF_BIT] <= 1'b0;
        // lag constants are captured a tick before the filters use them
        sfilt <= 16'h0005;
        tfilt <= 16'h0005;
        tick_wait(4);
        li.pos_cmd_delta <= 16'sh03e8;
        li.speed_cmd <= li.speed_cmd + 16'sh03e8;
        for (int j = 0; j < 4; j++) begin
            tick_wait(1);
            @(posedge core_clk);
            mx = lo.torque_cmd > mx ? lo.torque_cmd : mx;
        end
        cmp_bit(mx > 0 && mx < 1000 * (m_ratio + 100) / 100, 1'b1, "torque lag");
        cmp_bit(lo.speed_cmd > 0 && lo.speed_cmd < 1000, 1'b1, "speed lag");
        tick_wait(20);
        @(posedge core_clk);
        cmp_bit(lo.speed_cmd > 997 && lo.speed_cmd < 1001, 1'b1, "speed settle");
        hfilt <= ~hfilt;
        @(posedge core_clk);
        cmp_word(hfilt_act, ~hfilt, "held between ticks");
        tick_wait(1);
        @(posedge core_clk);
        cmp_word(hfilt_act, hfilt, "taken at tick");
        print_verdict();
    end
endmodule : inertia_select_feedforward_tb_top
`default_nettype wire
